//--- common/bpc_regs.vh
`ifndef BPC_REGS_VH
`define BPC_REGS_VH

// register indices; byte address is four times the index
`define BPC_IDX_PORT_DATA 4'h0
`define BPC_IDX_PIN_DIR 4'h1
`define BPC_IDX_OPTION 4'h2
`define BPC_IDX_IRQ_CONTROL 4'hB
`define BPC_IDX_IRQ_STATUS 4'hC
`define BPC_IDX_IRQ_MASK 4'hD

// axi4-lite
`define BPC_ADDR_W 12
`define BPC_RESP_OKAY 2'b00
`define BPC_RESP_SLVERR 2'b10

// option register fields
`define BPC_OPT_PULLUP_DIS_N 7
`define BPC_OPT_EDGE_SEL 6
`define BPC_OPTION_RESET 8'h00C0

// irq_control fields
`define BPC_IC_GLOBAL_EN 7
`define BPC_IC_EXT_EN 4
`define BPC_IC_CHANGE_EN 3
`define BPC_IC_EXT_FLAG 1
`define BPC_IC_CHANGE_FLAG 0
`define BPC_IRQ_CONTROL_RESET 8'h0000

// irq status / mask fields
`define BPC_ST_CHANGE 0
`define BPC_ST_EXT 1
`define BPC_ST_WAKE 2
`define BPC_ST_W 3

// port reset values
`define BPC_DIR_RESET 8'h00FF
`define BPC_LATCH_RESET 8'h0000

// change-watched, external interrupt and programming pins
`define BPC_WATCH_LO 4
`define BPC_WATCH_HI 7
`define BPC_PIN_EXT_IRQ 0
`define BPC_PIN_LVP_ENABLE 3
`define BPC_PIN_LVP_CLOCK 6
`define BPC_PIN_LVP_DATA 7

`endif

//--- hdl/bpc_pin_sync.v
`timescale 1ns/1ns
module bpc_pin_sync #(
    parameter WIDTH = 8
) (
    input wire core_clk,
    input wire rst,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut_r
);

reg [WIDTH-1:0] stage1_r;
reg [WIDTH-1:0] stage2_r;
reg [WIDTH-1:0] stage3_r;
integer i;

// stage1 feeds stage2 only; a bit moves once stages 2 and 3 agree
always @(posedge core_clk)
begin
    if (rst)
    begin
        stage1_r <= {WIDTH{1'b0}};
        stage2_r <= {WIDTH{1'b0}};
        stage3_r <= {WIDTH{1'b0}};
        syncOut_r <= {WIDTH{1'b0}};
    end
    else
    begin
        stage1_r <= asyncIn;
        stage2_r <= stage1_r;
        stage3_r <= stage2_r;
        for (i = 0; i < WIDTH; i = i + 1)
        begin
            if (stage2_r[i] == stage3_r[i])
            begin
                syncOut_r[i] <= stage3_r[i];
            end
        end
    end
end

endmodule // bpc_pin_sync

//--- hdl/bpc_port.v
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`include "bpc_regs.vh"
module bpc_port (
    input wire core_clk,
    input wire rst,
    // axi4-lite slave
    input wire [`BPC_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`BPC_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // port pins
    input wire [7:0] pinIn,
    output wire [7:0] pinOut,
    output wire [7:0] pinOe,
    output wire [7:0] pullupEn,
    // low-voltage programming
    input wire lvpMode,
    input wire lvpDataOut,
    input wire lvpDataOe,
    output wire lvpEnablePin,
    output wire lvpClockPin,
    output wire lvpDataPin,
    // interrupt and wake
    output wire irqRequest,
    output wire coreWake,
    output wire irq
);

reg [7:0] outLatch_r;
reg [7:0] pinDirection_r;
reg [7:0] option_r;
reg [7:0] irqControl_r;
reg [3:0] changeRef_r;
reg extPrev_r;
reg [`BPC_ST_W-1:0] irqStatus_r;
reg [`BPC_ST_W-1:0] irqMask_r;
reg awGot_r;
reg wGot_r;
reg [`BPC_ADDR_W-1:0] awAddr_r;
reg [31:0] wData_r;
reg [3:0] wStrb_r;

wire [7:0] pinSync;

bpc_pin_sync #(
    .WIDTH(8)
) pinSyncInst (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn(pinIn),
    .syncOut_r(pinSync)
);

// register index from a byte address; out-of-range marks unmapped
function [4:0] regIndex;
    input [`BPC_ADDR_W-1:0] addr;
    begin
        if (addr[1:0] != 2'b00 || addr[`BPC_ADDR_W-1:6] != 0)
        begin
            regIndex = 5'h10;
        end
        else
        begin
            regIndex = {1'b0, addr[5:2]};
        end
    end
endfunction

function isMapped;
    input [4:0] idx;
    begin
        case (idx)
            {1'b0, `BPC_IDX_PORT_DATA},
            {1'b0, `BPC_IDX_PIN_DIR},
            {1'b0, `BPC_IDX_OPTION},
            {1'b0, `BPC_IDX_IRQ_CONTROL},
            {1'b0, `BPC_IDX_IRQ_STATUS},
            {1'b0, `BPC_IDX_IRQ_MASK}: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    end
endfunction

// effective direction: programming mode forces its pins
wire [7:0] effDirection;
assign effDirection = lvpMode ?
    (pinDirection_r | (8'h0001 << `BPC_PIN_LVP_ENABLE) | (8'h0001 << `BPC_PIN_LVP_CLOCK)
        | (8'h0001 << `BPC_PIN_LVP_DATA)) : pinDirection_r;

wire lvpDriveData;
assign lvpDriveData = lvpMode & lvpDataOe;

assign pinOe = ~effDirection | (lvpDriveData ? (8'h0001 << `BPC_PIN_LVP_DATA) : 8'h0000);
assign pinOut = lvpMode ?
    ((outLatch_r & ~(8'h0001 << `BPC_PIN_LVP_DATA)) | ({7'h00, lvpDataOut} << `BPC_PIN_LVP_DATA))
    : outLatch_r;
assign lvpEnablePin = pinSync[`BPC_PIN_LVP_ENABLE];
assign lvpClockPin = pinSync[`BPC_PIN_LVP_CLOCK];
assign lvpDataPin = pinSync[`BPC_PIN_LVP_DATA];

// pull-ups follow the shared bit but never on a driven pin
assign pullupEn = {8{~option_r[`BPC_OPT_PULLUP_DIS_N]}} & ~pinOe;

// change detection on the watched inputs only
wire [3:0] watchInputs;
wire [3:0] watchMask;
wire mismatch;
assign watchInputs = pinSync[`BPC_WATCH_HI:`BPC_WATCH_LO];
assign watchMask = effDirection[`BPC_WATCH_HI:`BPC_WATCH_LO];
assign mismatch = |((watchInputs ^ changeRef_r) & watchMask);

// external interrupt edge on pin 0
wire extNow;
wire extEdge;
assign extNow = pinSync[`BPC_PIN_EXT_IRQ];
assign extEdge = option_r[`BPC_OPT_EDGE_SEL] ? (extNow & ~extPrev_r) : (~extNow & extPrev_r);

// axi write path: address and data may come in either order
wire awHand;
wire wHand;
wire wrFire;
wire [`BPC_ADDR_W-1:0] wrAddr;
wire [31:0] wrData;
wire [3:0] wrStrb;
wire [4:0] wrIdx;
wire wrOk;
wire wrLane0;
assign s_axi_awready = ~awGot_r & ~s_axi_bvalid;
assign s_axi_wready = ~wGot_r & ~s_axi_bvalid;
assign awHand = s_axi_awvalid & s_axi_awready;
assign wHand = s_axi_wvalid & s_axi_wready;
assign wrFire = (awGot_r | awHand) & (wGot_r | wHand);
assign wrAddr = awGot_r ? awAddr_r : s_axi_awaddr;
assign wrData = wGot_r ? wData_r : s_axi_wdata;
assign wrStrb = wGot_r ? wStrb_r : s_axi_wstrb;
assign wrIdx = regIndex(wrAddr);
assign wrOk = isMapped(wrIdx);
// registers are one byte wide; lane 0 carries them
assign wrLane0 = wrFire & wrOk & wrStrb[0];

wire wrPort;
wire wrDir;
wire wrOption;
wire wrControl;
wire wrStatus;
wire wrMask;
assign wrPort = wrLane0 & (wrIdx == {1'b0, `BPC_IDX_PORT_DATA});
assign wrDir = wrLane0 & (wrIdx == {1'b0, `BPC_IDX_PIN_DIR});
assign wrOption = wrLane0 & (wrIdx == {1'b0, `BPC_IDX_OPTION});
assign wrControl = wrLane0 & (wrIdx == {1'b0, `BPC_IDX_IRQ_CONTROL});
assign wrStatus = wrLane0 & (wrIdx == {1'b0, `BPC_IDX_IRQ_STATUS});
assign wrMask = wrLane0 & (wrIdx == {1'b0, `BPC_IDX_IRQ_MASK});

// axi read path
wire arHand;
wire [4:0] rdIdx;
wire rdPort;
assign s_axi_arready = ~s_axi_rvalid;
assign arHand = s_axi_arvalid & s_axi_arready;
assign rdIdx = regIndex(s_axi_araddr);
assign rdPort = arHand & (rdIdx == {1'b0, `BPC_IDX_PORT_DATA});

reg [7:0] rdValue;
always @*
begin
    case (rdIdx)
        {1'b0, `BPC_IDX_PORT_DATA}: rdValue = pinSync;
        {1'b0, `BPC_IDX_PIN_DIR}: rdValue = pinDirection_r;
        {1'b0, `BPC_IDX_OPTION}: rdValue = option_r;
        {1'b0, `BPC_IDX_IRQ_CONTROL}: rdValue = irqControl_r;
        {1'b0, `BPC_IDX_IRQ_STATUS}: rdValue = {5'h00, irqStatus_r};
        {1'b0, `BPC_IDX_IRQ_MASK}: rdValue = {5'h00, irqMask_r};
        default: rdValue = 8'h0000;
    endcase
end

// flag next values; hardware set wins over a software clear
wire changeFlag_nxt;
wire extFlag_nxt;
wire [7:0] controlWrMask;
wire [7:0] irqControl_nxt;
assign controlWrMask = (8'h0001 << `BPC_IC_GLOBAL_EN) | (8'h0001 << `BPC_IC_EXT_EN)
    | (8'h0001 << `BPC_IC_CHANGE_EN);
assign changeFlag_nxt = mismatch
    | (wrControl ? wrData[`BPC_IC_CHANGE_FLAG] : irqControl_r[`BPC_IC_CHANGE_FLAG]);
assign extFlag_nxt = extEdge
    | (wrControl ? wrData[`BPC_IC_EXT_FLAG] : irqControl_r[`BPC_IC_EXT_FLAG]);
assign irqControl_nxt = ((wrControl ? wrData[7:0] : irqControl_r) & controlWrMask)
    | ({7'h00, changeFlag_nxt} << `BPC_IC_CHANGE_FLAG)
    | ({7'h00, extFlag_nxt} << `BPC_IC_EXT_FLAG);

wire wakeEvent;
assign wakeEvent = irqControl_r[`BPC_IC_CHANGE_FLAG] & irqControl_r[`BPC_IC_CHANGE_EN];

wire [`BPC_ST_W-1:0] statusEvents;
wire [`BPC_ST_W-1:0] irqStatus_nxt;
assign statusEvents = ({2'b00, mismatch} << `BPC_ST_CHANGE) | ({2'b00, extEdge} << `BPC_ST_EXT)
    | ({2'b00, wakeEvent} << `BPC_ST_WAKE);
assign irqStatus_nxt = statusEvents
    | (irqStatus_r & ~(wrStatus ? wrData[`BPC_ST_W-1:0] : {`BPC_ST_W{1'b0}}));

always @(posedge core_clk)
begin
    if (rst)
    begin
        outLatch_r <= `BPC_LATCH_RESET;
        pinDirection_r <= `BPC_DIR_RESET;
        option_r <= `BPC_OPTION_RESET;
        irqControl_r <= `BPC_IRQ_CONTROL_RESET;
        changeRef_r <= 4'h0;
        extPrev_r <= 1'b0;
        irqStatus_r <= {`BPC_ST_W{1'b0}};
        irqMask_r <= {`BPC_ST_W{1'b0}};
    end
    else
    begin
        extPrev_r <= extNow;
        irqControl_r <= irqControl_nxt;
        irqStatus_r <= irqStatus_nxt;
        if (wrPort)
        begin
            outLatch_r <= wrData[7:0];
        end
        if (wrDir)
        begin
            pinDirection_r <= wrData[7:0];
        end
        if (wrOption)
        begin
            option_r <= wrData[7:0] & ((8'h0001 << `BPC_OPT_PULLUP_DIS_N) | (8'h0001 << `BPC_OPT_EDGE_SEL));
        end
        if (wrMask)
        begin
            irqMask_r <= wrData[`BPC_ST_W-1:0];
        end
        // a port access re-arms the comparison against present levels
        if (rdPort | wrPort)
        begin
            changeRef_r <= watchInputs;
        end
    end
end

// axi handshake state
always @(posedge core_clk)
begin
    if (rst)
    begin
        awGot_r <= 1'b0;
        wGot_r <= 1'b0;
        awAddr_r <= {`BPC_ADDR_W{1'b0}};
        wData_r <= 32'h0000_0000;
        wStrb_r <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `BPC_RESP_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `BPC_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
        if (wrFire)
        begin
            awGot_r <= 1'b0;
            wGot_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrOk ? `BPC_RESP_OKAY : `BPC_RESP_SLVERR;
        end
        else
        begin
            if (awHand)
            begin
                awGot_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (wHand)
            begin
                wGot_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
        if (arHand)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rdValue};
            s_axi_rresp <= isMapped(rdIdx) ? `BPC_RESP_OKAY : `BPC_RESP_SLVERR;
        end
        else if (s_axi_rvalid & s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// request only with flag, its enable and the global enable
assign irqRequest = irqControl_r[`BPC_IC_GLOBAL_EN]
    & ((irqControl_r[`BPC_IC_CHANGE_FLAG] & irqControl_r[`BPC_IC_CHANGE_EN])
    | (irqControl_r[`BPC_IC_EXT_FLAG] & irqControl_r[`BPC_IC_EXT_EN]));
// wake does not need the global enable, as a sleeping core polls nothing
assign coreWake = wakeEvent;
assign irq = |(irqStatus_r & irqMask_r);

endmodule // bpc_port

//--- dv/bpc_port_properties.sv
`timescale 1ns/1ns
module bpc_port_properties (
    input wire core_clk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] pinOe,
    input wire [7:0] pullupEn,
    input wire lvpMode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_reset_pullups_off: assert property (disable iff (1'b0) rst |=> pullupEn == 8'h00)
        else $error("pull-ups on after reset");
    // programming mode owns pins 3, 6 and 7; the pattern holds in it as well but is checked only outside it
    a_pullup_pattern: assert property (!lvpMode |-> pullupEn == 8'h00 || pullupEn == ~pinOe)
        else $error("pull-ups not all inputs or on an output");
    a_drive_cause: assert property (!lvpMode && !$past(lvpMode) && $changed(pinOe) |->
        $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready))
        else $error("pin drivers changed without a write");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("no write response one cycle after write");
    a_bvalid_cause: assert property ($rose(s_axi_bvalid) |->
        $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready))
        else $error("write response without a write");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after acceptance");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data one cycle after read");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after acceptance");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule // bpc_port_properties

bind bpc_port bpc_port_properties bpc_port_properties_i (
    .core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .pinOe, .pullupEn, .lvpMode
);

//--- dv/bpc_pin_model.sv
`timescale 1ns/1ns
module bpc_pin_model (
    input wire core_clk,
    input wire [7:0] pinOut,
    input wire [7:0] pinOe,
    input wire [7:0] pullupEn,
    input wire [7:0] keyDrive,
    input wire [7:0] keyLevel,
    output wire [7:0] pinIn
);
    reg [7:0] lastLevel = 8'h00;
    reg [7:0] level;

    // an undriven pin without pull-up wanders instead of keeping its value
    always @*
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pinOe[i]) level[i] = pinOut[i];
            else if (keyDrive[i]) level[i] = keyLevel[i];
            else if (pullupEn[i]) level[i] = 1'b1;
            else level[i] = ~lastLevel[i];
        end
    end
    always @(posedge core_clk) lastLevel <= level;
    assign pinIn = level;
endmodule // bpc_pin_model

//--- dv/bpc_port_tb.sv
`timescale 1ns/1ns
`include "bpc_regs.vh"
module bpc_port_tb;
    localparam logic [11:0] ADDR_PORT = 12'h000, ADDR_DIR = 12'h004, ADDR_OPT = 12'h008;
    localparam logic [11:0] ADDR_IC = 12'h02c, ADDR_ST = 12'h030, ADDR_MSK = 12'h034;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic lvpMode = 1'b0, lvpDataOut = 1'b0, lvpDataOe = 1'b0;
    logic [7:0] keyDrive = 8'hff, keyLevel = 8'h00, mLat = 8'h00, mDir = 8'hff;
    logic [31:0] seed = 32'h6b85;
    logic [31:0] d;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] pinIn, pinOut, pinOe, pullupEn;
    wire lvpEnablePin, lvpClockPin, lvpDataPin, irqRequest, coreWake, irq;
    int badCount = 0, numChecks = 0;

    bpc_port bpc_port_i (
        .core_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'b000), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .pinOut, .pinOe, .pullupEn,
        .lvpMode, .lvpDataOut, .lvpDataOe, .lvpEnablePin, .lvpClockPin, .lvpDataPin,
        .irqRequest, .coreWake, .irq
    );
    bpc_pin_model bpc_pin_model_i (.core_clk, .pinOut, .pinOe, .pullupEn, .keyDrive, .keyLevel, .pinIn);

    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] pinsExp();
        return (mLat & ~mDir) | (keyLevel & mDir);
    endfunction

    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: value %h, want %h", $time, got, exp);
        end
    endtask

    task automatic checkResp(input logic [1:0] got, input logic [1:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: response %b, want %b", $time, got, exp);
        end
    endtask

    task automatic axiWrite(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // each half is released at the edge that takes it, whatever the order
        while (!(awDone && wDone))
        begin
            @(posedge core_clk);
            if (!awDone && s_axi_awready)
            begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready)
            begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        checkResp(s_axi_bresp, er);
    endtask

    task automatic axiRead(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        checkResp(s_axi_rresp, er);
    endtask

    task automatic readCheck(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] v;
        axiRead(a, v, 2'b00);
        checkVal(v, e);
    endtask

    // pin path is four sync edges plus one for the mismatch
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask

    task automatic closeOut();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #40000;
        badCount++;
        closeOut();
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        readCheck(ADDR_DIR, 32'h0000_00ff);
        readCheck(ADDR_OPT, 32'h0000_00c0);
        readCheck(ADDR_IC, 32'h0000_0000);
        checkVal({pinOe, pullupEn}, 32'h0000_0000);
        repeat (4)
        begin
            mLat = rnd();
            mDir = rnd();
            keyLevel <= rnd();
            axiWrite(ADDR_PORT, mLat, 2'b00);
            axiWrite(ADDR_DIR, mDir, 2'b00);
            checkVal(pinOe ^ mDir, 32'h0000_00ff);
            checkVal(pinOut & ~mDir, mLat & ~mDir);
            settle();
            readCheck(ADDR_PORT, pinsExp());
        end
        axiWrite(ADDR_OPT, 32'h0000_0040, 2'b00);
        checkVal(pullupEn, mDir);
        // keys let go: inputs must float up on the pull-ups
        keyDrive <= 8'h00;
        settle();
        readCheck(ADDR_PORT, mLat | mDir);
        keyDrive <= 8'hff;
        axiWrite(ADDR_OPT, 32'h0000_00c0, 2'b00);
        checkVal(pullupEn, 32'h0000_0000);
        mDir = 8'hf1;
        mLat = 8'h80;
        axiWrite(ADDR_PORT, mLat, 2'b00);
        axiWrite(ADDR_DIR, mDir, 2'b00);
        keyLevel <= 8'h00;
        settle();
        readCheck(ADDR_PORT, pinsExp());
        axiWrite(ADDR_IC, 32'h0000_0088, 2'b00);
        axiWrite(ADDR_ST, 32'h0000_0007, 2'b00);
        // pin 7 turns output and moves off its reference; it must not count
        mDir = 8'h71;
        axiWrite(ADDR_DIR, mDir, 2'b00);
        keyLevel <= 8'h8e;
        settle();
        readCheck(ADDR_IC, 32'h0000_0088);
        keyLevel <= 8'hae;
        settle();
        readCheck(ADDR_IC, 32'h0000_0089);
        checkVal({irqRequest, coreWake, irq}, 32'h0000_0006);
        readCheck(ADDR_ST, 32'h0000_0005);
        axiWrite(ADDR_IC, 32'h0000_0088, 2'b00);
        readCheck(ADDR_IC, 32'h0000_0089);
        axiWrite(ADDR_MSK, 32'h0000_0001, 2'b00);
        checkVal(irq, 32'h0000_0001);
        readCheck(ADDR_PORT, pinsExp());
        axiWrite(ADDR_IC, 32'h0000_0088, 2'b00);
        axiWrite(ADDR_ST, 32'h0000_0007, 2'b00);
        readCheck(ADDR_IC, 32'h0000_0088);
        checkVal({irqRequest, coreWake, irq}, 32'h0000_0000);
        keyLevel <= 8'h8e;
        settle();
        axiWrite(ADDR_PORT, mLat, 2'b00);
        axiWrite(ADDR_IC, 32'h0000_0088, 2'b00);
        readCheck(ADDR_IC, 32'h0000_0088);
        for (int e = 0; e < 2; e++)
        begin
            axiWrite(ADDR_OPT, 32'h0000_0080 | (e << 6), 2'b00);
            keyLevel[0] <= e[0];
            settle();
            axiWrite(ADDR_IC, 32'h0000_0090, 2'b00);
            // the inactive edge first, then the selected one
            keyLevel[0] <= ~e[0];
            settle();
            readCheck(ADDR_IC, 32'h0000_0090);
            keyLevel[0] <= e[0];
            settle();
            readCheck(ADDR_IC, 32'h0000_0092);
        end
        axiWrite(12'h010, 32'h0000_00ff, 2'b10);
        axiRead(12'h010, d, 2'b10);
        checkVal(d, 32'h0000_0000);
        lvpMode <= 1'b1;
        lvpDataOe <= 1'b1;
        lvpDataOut <= 1'b1;
        axiWrite(ADDR_DIR, 32'h0000_0000, 2'b00);
        keyLevel <= 8'h40;
        settle();
        checkVal(pinOe, 32'h0000_00b7);
        checkVal({lvpEnablePin, lvpClockPin, lvpDataPin}, 32'h0000_0003);
        closeOut();
    end
endmodule // bpc_port_tb
